// ===== src/tss_defines.svh
`ifndef TSS_DEFINES_SVH
`define TSS_DEFINES_SVH

// Link command codes
`define TSS_CMD_CLEAR_FAULTS  8'h03
`define TSS_CMD_SNAPSHOT      8'hE0
`define TSS_CMD_SUMMARY       8'hE1
`define TSS_CMD_AVERAGED      8'hE2
`define TSS_CMD_AUX_HIGH      8'hE3
`define TSS_CMD_AUX_LOW       8'hE4

// Summary word bit positions
`define TSS_BIT_OCOP_WARN     14
`define TSS_BIT_IN_LOW_WARN   13
`define TSS_BIT_IN_HIGH_WARN  12
`define TSS_BIT_OVERTEMP_WARN_FLAG       10
`define TSS_BIT_AUX_LOW_WARN  9
`define TSS_BIT_AUX_HIGH_WARN 8
`define TSS_BIT_PRESET        7
`define TSS_BIT_OT_FAULT      2
`define TSS_BIT_COMM_FAULT    1

// Reset values and limits
`define TSS_SUMMARY_RST       16'h0080
`define TSS_SUMMARY_KEEP      16'h0080
`define TSS_AUX_HIGH_RST      12'hFFF
`define TSS_AUX_LOW_RST       12'h000
`define TSS_AUX_HIGH_OFF      12'hFFF
`define TSS_AUX_LOW_OFF       12'h000
`define TSS_BLOCK_COUNT       8'h0C
`define TSS_BLOCK_LEN         4'hD
`define TSS_WORD_LEN          4'h2

// Live refresh period against the 50 ns clock, rounded down, at least one
`define TSS_CLK_PERIOD_NS     50
`define TSS_LIVE_PERIOD_NS    85
`define TSS_LIVE_CYCLES       ((`TSS_LIVE_PERIOD_NS / `TSS_CLK_PERIOD_NS) < 1 ? 1 : \
                               (`TSS_LIVE_PERIOD_NS / `TSS_CLK_PERIOD_NS))

// Controller APB register offsets
`define TSS_APB_CTRL          8'h00
`define TSS_APB_WDATA         8'h04
`define TSS_APB_STATUS        8'h08
`define TSS_APB_RDATA0        8'h0C
`define TSS_APB_RDATA1        8'h10
`define TSS_APB_RDATA2        8'h14
`define TSS_APB_COUNT         8'h18
`define TSS_CTRL_START_BIT    16

`endif

// ===== src/tss_pkg.sv
package tss_pkg;

    typedef enum logic [1:0] {
        XFER_SEND_BYTE  = 2'b00,
        XFER_WRITE_WORD = 2'b01,
        XFER_READ_WORD  = 2'b10,
        XFER_READ_BLOCK = 2'b11
    } tss_xfer_t;

    typedef enum logic [0:0] {
        HOST_IDLE = 1'b0,
        HOST_WAIT = 1'b1
    } tss_host_state_t;

endpackage : tss_pkg

// ===== src/tss_link_if.sv
interface tss_link_if (
    input logic clk_i
);
    import tss_pkg::*;

    logic            req;
    tss_xfer_t       xfer;
    logic [7:0]      cmd;
    logic [15:0]     wdata;
    logic            rvalid;
    logic [7:0]      rbyte;
    logic            done;
    logic            nack;
    logic            alert;

    modport dev (
        input  req,
        input  xfer,
        input  cmd,
        input  wdata,
        output rvalid,
        output rbyte,
        output done,
        output nack,
        output alert
    );

    modport host (
        output req,
        output xfer,
        output cmd,
        output wdata,
        input  rvalid,
        input  rbyte,
        input  done,
        input  nack,
        input  alert
    );

endinterface : tss_link_if

// ===== src/tss_byte_tx.sv
module tss_byte_tx (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Load side
    input  wire logic         load_i,
    input  wire logic [103:0] frame_i,
    input  wire logic [3:0]   len_i,
    input  wire logic         nack_i,
    output logic              busy_o,
    // Byte stream
    output logic              rvalid_o,
    output logic [7:0]        rbyte_o,
    output logic              done_o,
    output logic              nack_o
);
    import tss_pkg::*;

    typedef struct packed {
        logic         busy;
        logic [103:0] frame;
        logic [3:0]   left;
        logic         hold_nack;
        logic         rvalid;
        logic [7:0]   rbyte;
        logic         done;
        logic         nack;
    } tss_tx_state_t;

    tss_tx_state_t s;
    tss_tx_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.rvalid = 1'b0;
        next_s.done   = 1'b0;
        next_s.nack   = 1'b0;
        if (!s.busy && load_i) begin
            next_s.busy      = 1'b1;
            next_s.frame     = frame_i;
            next_s.left      = len_i;
            next_s.hold_nack = nack_i;
        end else if (s.busy) begin
            if (s.left != 4'h0) begin
                // Low byte leaves first
                next_s.rvalid = 1'b1;
                next_s.rbyte  = s.frame[7:0];
                next_s.frame  = {8'h00, s.frame[103:8]};
                next_s.left   = s.left - 4'h1;
            end else begin
                next_s.done = 1'b1;
                next_s.nack = s.hold_nack;
                next_s.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign busy_o   = s.busy;
    assign rvalid_o = s.rvalid;
    assign rbyte_o  = s.rbyte;
    assign done_o   = s.done;
    assign nack_o   = s.nack;

endmodule : tss_byte_tx

// ===== src/tss_device.sv
// Notes on behaviour
// - First alert freezes live bundle; E0h returns it
// - Snapshot disarmed until clear-faults command
// - Snapshot same layout, loaded only on alert
// - E1h returns every fault and warning flag
// - Summary word leads every bundle
// - Warning bits 14,13,12,10,9,8 reset zero
// - Bits 2,1 faults; bit 7 preset; reserved zero
// - E2h: count 12, six words fixed order
// - Averaged values captured together, time-aligned
// - Host reads averaged bundle by block read
// - Aux above E3h threshold sets warning, alert
// - High threshold 0FFFh disables detection
// - Aux below E4h threshold sets warning, alert
// - Low threshold 0000h disables detection
// - Thresholds accessed only by word transfers
// - Words travel low byte first, 12 bits
// - Values 0..4095, temperature up to 65535
// - Host scales words by m, b, R
// - Live bundle refreshes only while link idle
// - Range select changes current and power scaling; here only registered to range_o
//
// Design decision made here: register access over APB.
`include "tss_defines.svh"

module tss_device (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Link to the host
    tss_link_if.dev            link,
    // Live telemetry
    input  wire logic [11:0]   input_current_i,
    input  wire logic [11:0]   aux_voltage_i,
    input  wire logic [11:0]   input_voltage_i,
    input  wire logic [11:0]   power_i,
    input  wire logic [15:0]   temperature_i,
    // Averaged telemetry, all four valid together
    input  wire logic          avg_valid_i,
    input  wire logic [11:0]   avg_input_current_i,
    input  wire logic [11:0]   avg_aux_voltage_i,
    input  wire logic [11:0]   avg_input_voltage_i,
    input  wire logic [11:0]   avg_power_i,
    // Conditions from the other monitors
    input  wire logic          overcurrent_warn_i,
    input  wire logic          overpower_warn_i,
    input  wire logic          input_low_warn_i,
    input  wire logic          input_high_warn_i,
    input  wire logic          overtemp_warn_i,
    input  wire logic          overtemp_fault_i,
    input  wire logic          range_sel_i,
    // Status
    output logic               alert_o,
    output logic               range_o,
    output logic [15:0]        summary_o,
    output logic               snapshot_armed_o
);
    import tss_pkg::*;

    typedef struct packed {
        logic [95:0] live;
        logic [95:0] snap;
        logic [95:0] avg;
        logic [15:0] summary;
        logic [11:0] aux_high;
        logic [11:0] aux_low;
        logic        armed;
        logic        alert;
        logic        range;
    } tss_dev_state_t;

    tss_dev_state_t s;
    tss_dev_state_t next_s;

    logic         tx_load;
    logic [103:0] tx_frame;
    logic [3:0]   tx_len;
    logic         tx_nack;
    logic         tx_busy;
    logic [15:0]  set_bits;
    logic         bad_req;
    logic         clear_req;

    function automatic logic [15:0] word12(input logic [11:0] v);
        word12 = {4'h0, v};
    endfunction : word12

    tss_byte_tx u_tx (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .load_i   (tx_load),
        .frame_i  (tx_frame),
        .len_i    (tx_len),
        .nack_i   (tx_nack),
        .busy_o   (tx_busy),
        .rvalid_o (link.rvalid),
        .rbyte_o  (link.rbyte),
        .done_o   (link.done),
        .nack_o   (link.nack)
    );

    always_comb begin
        next_s    = s;
        tx_load   = 1'b0;
        tx_frame  = '0;
        tx_len    = 4'h0;
        tx_nack   = 1'b0;
        bad_req   = 1'b0;
        clear_req = 1'b0;
        set_bits  = 16'h0000;

        // Request decode; a request that arrives while an answer is still going out is ignored
        if (link.req && !tx_busy) begin
            tx_load = 1'b1;
            case (link.cmd)
                `TSS_CMD_SNAPSHOT: begin
                    if (link.xfer == XFER_READ_BLOCK) begin
                        tx_frame = {s.snap, `TSS_BLOCK_COUNT};
                        tx_len   = `TSS_BLOCK_LEN;
                    end else begin
                        bad_req = 1'b1;
                    end
                end
                `TSS_CMD_SUMMARY: begin
                    if (link.xfer == XFER_READ_WORD) begin
                        tx_frame = {88'h0, s.summary};
                        tx_len   = `TSS_WORD_LEN;
                    end else begin
                        bad_req = 1'b1;
                    end
                end
                `TSS_CMD_AVERAGED: begin
                    if (link.xfer == XFER_READ_BLOCK) begin
                        tx_frame = {s.avg, `TSS_BLOCK_COUNT};
                        tx_len   = `TSS_BLOCK_LEN;
                    end else begin
                        bad_req = 1'b1;
                    end
                end
                `TSS_CMD_AUX_HIGH, `TSS_CMD_AUX_LOW: begin
                    // Word transfers only; values above 4095 are refused
                    if (link.xfer == XFER_READ_WORD) begin
                        tx_frame = {88'h0, word12(link.cmd == `TSS_CMD_AUX_HIGH ?
                                                  s.aux_high : s.aux_low)};
                        tx_len   = `TSS_WORD_LEN;
                    end else if (link.xfer == XFER_WRITE_WORD &&
                                 link.wdata[15:12] == 4'h0) begin
                        if (link.cmd == `TSS_CMD_AUX_HIGH) begin
                            next_s.aux_high = link.wdata[11:0];
                        end else begin
                            next_s.aux_low = link.wdata[11:0];
                        end
                        // Limits no longer at their defaults
                        next_s.summary[`TSS_BIT_PRESET] = 1'b0;
                    end else begin
                        bad_req = 1'b1;
                    end
                end
                `TSS_CMD_CLEAR_FAULTS: begin
                    if (link.xfer == XFER_SEND_BYTE) begin
                        clear_req = 1'b1;
                    end else begin
                        bad_req = 1'b1;
                    end
                end
                default: begin
                    bad_req = 1'b1;
                end
            endcase
            if (bad_req) begin
                tx_frame = '0;
                tx_len   = 4'h0;
                tx_nack  = 1'b1;
            end
        end

        // Condition events
        set_bits[`TSS_BIT_OCOP_WARN]    = overcurrent_warn_i | overpower_warn_i;
        set_bits[`TSS_BIT_IN_LOW_WARN]  = input_low_warn_i;
        set_bits[`TSS_BIT_IN_HIGH_WARN] = input_high_warn_i;
        set_bits[`TSS_BIT_OVERTEMP_WARN_FLAG]      = overtemp_warn_i;
        set_bits[`TSS_BIT_AUX_HIGH_WARN] = (s.aux_high != `TSS_AUX_HIGH_OFF) &&
                                          (aux_voltage_i > s.aux_high);
        set_bits[`TSS_BIT_AUX_LOW_WARN]  = (s.aux_low != `TSS_AUX_LOW_OFF) &&
                                          (aux_voltage_i < s.aux_low);
        set_bits[`TSS_BIT_OT_FAULT]     = overtemp_fault_i;
        set_bits[`TSS_BIT_COMM_FAULT]   = bad_req;

        // Sticky flags; an event in the clearing cycle survives
        if (clear_req) begin
            next_s.summary = next_s.summary & `TSS_SUMMARY_KEEP;
            next_s.armed   = 1'b1;
        end
        next_s.summary = next_s.summary | set_bits;

        // Alert follows any warning or fault, not the preset flag
        next_s.alert = |(next_s.summary & ~`TSS_SUMMARY_KEEP);

        // Frozen once per arming, from the live bundle at the alert edge
        if (s.alert && s.armed && !clear_req) begin
            next_s.snap  = s.live;
            next_s.armed = 1'b0;
        end

        // Held during a transfer so an answer in flight stays coherent
        if (!tx_busy && !link.req) begin
            next_s.live = {temperature_i, word12(power_i), word12(input_voltage_i),
                           word12(aux_voltage_i), word12(input_current_i),
                           next_s.summary};
        end

        // All averages taken on one strobe; temperature has no average
        if (avg_valid_i) begin
            next_s.avg = {temperature_i, word12(avg_power_i), word12(avg_input_voltage_i),
                          word12(avg_aux_voltage_i), word12(avg_input_current_i),
                          s.summary};
        end else begin
            next_s.avg[15:0] = s.summary;
        end

        next_s.range = range_sel_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s          <= '0;
            s.summary  <= `TSS_SUMMARY_RST;
            s.aux_high <= `TSS_AUX_HIGH_RST;
            s.aux_low  <= `TSS_AUX_LOW_RST;
            s.armed    <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign link.alert       = s.alert;
    assign alert_o          = s.alert;
    assign range_o          = s.range;
    assign summary_o        = s.summary;
    assign snapshot_armed_o = s.armed;

endmodule : tss_device

// ===== src/tss_host.sv
`include "tss_defines.svh"

module tss_host (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // APB slave
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [7:0]   paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic [31:0]       prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    // Link to the device
    tss_link_if.host          link,
    // Status
    output logic              alert_o
);
    import tss_pkg::*;

    typedef struct packed {
        tss_host_state_t fsm;
        logic            req;
        tss_xfer_t       xfer;
        logic [7:0]      cmd;
        logic [15:0]     wdata;
        logic [95:0]     rbuf;
        logic [7:0]      count;
        logic            got_count;
        logic [3:0]      idx;
        logic            nack;
        logic            alert;
        logic [31:0]     prdata;
        logic            pready;
        logic            pslverr;
    } tss_host_st_t;

    tss_host_st_t s;
    tss_host_st_t next_s;
    logic         mapped;

    // Transfer kind is fixed by the command where the device demands one
    function automatic tss_xfer_t pick_xfer(input logic [7:0] c, input tss_xfer_t want);
        case (c)
            `TSS_CMD_SNAPSHOT, `TSS_CMD_AVERAGED: pick_xfer = XFER_READ_BLOCK;
            `TSS_CMD_SUMMARY: pick_xfer = XFER_READ_WORD;
            `TSS_CMD_AUX_HIGH, `TSS_CMD_AUX_LOW:
                pick_xfer = (want == XFER_WRITE_WORD) ? XFER_WRITE_WORD
                                                      : XFER_READ_WORD;
            `TSS_CMD_CLEAR_FAULTS: pick_xfer = XFER_SEND_BYTE;
            default: pick_xfer = want;
        endcase
    endfunction : pick_xfer

    always_comb begin
        next_s       = s;
        next_s.req   = 1'b0;
        next_s.alert = link.alert;
        mapped       = (paddr_i <= `TSS_APB_COUNT) && (paddr_i[1:0] == 2'b00);

        // Answer one cycle into the access phase, data from a flop
        if (psel_i && penable_i && !s.pready) begin
            next_s.pready  = 1'b1;
            next_s.pslverr = !mapped;
            case (paddr_i)
                `TSS_APB_CTRL:   next_s.prdata = {22'h0, s.xfer, s.cmd};
                `TSS_APB_WDATA:  next_s.prdata = {16'h0, s.wdata};
                `TSS_APB_STATUS: next_s.prdata = {29'h0, s.alert, s.nack,
                                                  s.fsm == HOST_WAIT};
                `TSS_APB_RDATA0: next_s.prdata = s.rbuf[31:0];
                `TSS_APB_RDATA1: next_s.prdata = s.rbuf[63:32];
                `TSS_APB_RDATA2: next_s.prdata = s.rbuf[95:64];
                `TSS_APB_COUNT:  next_s.prdata = {24'h0, s.count};
                default:         next_s.prdata = 32'h0000_0000;
            endcase
        end else begin
            next_s.pready  = 1'b0;
            next_s.pslverr = 1'b0;
            next_s.prdata  = 32'h0000_0000;
        end

        // Writes land on the completing edge; start ignored while busy
        if (psel_i && penable_i && s.pready && pwrite_i && mapped) begin
            if (paddr_i == `TSS_APB_CTRL) begin
                next_s.cmd  = pwdata_i[7:0];
                next_s.xfer = pick_xfer(pwdata_i[7:0], tss_xfer_t'(pwdata_i[9:8]));
                if (pwdata_i[`TSS_CTRL_START_BIT] && s.fsm == HOST_IDLE) begin
                    next_s.req       = 1'b1;
                    next_s.fsm       = HOST_WAIT;
                    next_s.nack      = 1'b0;
                    next_s.idx       = 4'h0;
                    next_s.got_count = 1'b0;
                    next_s.count     = 8'h00;
                    next_s.rbuf      = '0;
                end
            end else if (paddr_i == `TSS_APB_WDATA) begin
                next_s.wdata = pwdata_i[15:0];
            end
        end

        case (s.fsm)
            HOST_IDLE: begin
                next_s.fsm = next_s.fsm;
            end
            HOST_WAIT: begin
                if (link.rvalid) begin
                    if (s.xfer == XFER_READ_BLOCK && !s.got_count) begin
                        next_s.count     = link.rbyte;
                        next_s.got_count = 1'b1;
                    end else if (s.idx < 4'hC) begin
                        next_s.rbuf[{s.idx, 3'b000} +: 8] = link.rbyte;
                        next_s.idx = s.idx + 4'h1;
                    end
                end
                if (link.done) begin
                    next_s.nack = link.nack;
                    next_s.fsm  = HOST_IDLE;
                end
            end
            default: begin
                next_s.fsm = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.req   = s.req;
    assign link.xfer  = s.xfer;
    assign link.cmd   = s.cmd;
    assign link.wdata = s.wdata;
    assign prdata_o   = s.prdata;
    assign pready_o   = s.pready;
    assign pslverr_o  = s.pslverr;
    assign alert_o    = s.alert;

endmodule : tss_host

// ===== testbench/tss_link_sva.sv
module tss_link_sva (
    // Clock and reset
    input wire logic               clk_i,
    input wire logic               rst_i,
    // Link signals
    input wire logic               req,
    input wire tss_pkg::tss_xfer_t xfer,
    input wire logic [7:0]         cmd,
    input wire logic [15:0]        wdata,
    input wire logic               rvalid,
    input wire logic [7:0]         rbyte,
    input wire logic               done,
    input wire logic               nack
);
    timeunit 1ns;
    timeprecision 1ns;
    import tss_pkg::*;

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic blk;
    logic thr;
    logic known;
    assign blk   = req && xfer == XFER_READ_BLOCK && cmd inside {8'hE0, 8'hE2};
    assign thr   = cmd inside {8'hE3, 8'hE4};
    assign known = cmd inside {8'h03, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4};

    done_bound_a: assert property (req |-> ##[2:15] done)
        else $error("transfer did not end in time");
    one_at_time_a: assert property (req |=> (!req until_with done))
        else $error("request during a transfer");
    word_read_a: assert property (req && xfer == XFER_READ_WORD && cmd == 8'hE1 |->
        ##2 rvalid ##1 rvalid ##1 (done && !nack)) else $error("summary read malformed");
    block_count_a: assert property (blk |-> ##2 (rvalid && rbyte == 8'h0C))
        else $error("block count byte wrong");
    block_len_a: assert property (blk |-> ##2 rvalid [*8] ##1 rvalid [*5] ##1 done)
        else $error("block length wrong");
    thr_write_a: assert property (req && xfer == XFER_WRITE_WORD && thr && wdata <= 16'h0FFF
        |-> ##2 (done && !nack && !rvalid)) else $error("threshold write refused");
    range_refuse_a: assert property (req && xfer == XFER_WRITE_WORD && wdata > 16'h0FFF
        |-> ##2 (done && nack)) else $error("oversized value accepted");
    thr_nibble_a: assert property (req && xfer == XFER_READ_WORD && thr
        |-> ##3 (rvalid && rbyte[7:4] == 4'h0)) else $error("threshold high byte not clean");
    clear_ack_a: assert property (req && xfer == XFER_SEND_BYTE && cmd == 8'h03
        |-> ##2 (done && !nack)) else $error("clear command refused");
    unknown_cmd_a: assert property (req && !known |-> ##2 (done && nack))
        else $error("unknown command accepted");
    nack_done_a: assert property (nack |-> done && !rvalid)
        else $error("refusal outside transfer end");
endmodule : tss_link_sva

// ===== testbench/telemetry_snapshot_status_bench.sv
`include "tss_defines.svh"

module telemetry_snapshot_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tss_pkg::*;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [1:0]  xf;
        logic [15:0] wd;
        logic        nk;
        logic [15:0] rd;
    } tss_row_t;

    logic        clk_i, rst_i, psel, penable, pwrite, pready, pslverr, av, rsel, pe, nk;
    logic        alert_d, alert_h, range_o, armed;
    logic [7:0]  paddr, cnt;
    logic [31:0] pwdata, prdata, pr;
    logic [11:0] cur, aux, input_voltage, pw, acur, aaux, avin, apw;
    logic [15:0] temp, summary;
    logic [5:0]  cond;
    logic [95:0] rd, snap;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    tss_row_t rows [10] = '{
        '{8'hE3, 2'h1, 16'h0ABC, 1'b0, 16'h0000},
        '{8'hE3, 2'h2, 16'h0000, 1'b0, 16'h0ABC},
        '{8'hE4, 2'h1, 16'h0123, 1'b0, 16'h0000},
        '{8'hE4, 2'h2, 16'h0000, 1'b0, 16'h0123},
        '{8'hE3, 2'h1, 16'h1000, 1'b1, 16'h0000},
        '{8'hE3, 2'h2, 16'h0000, 1'b0, 16'h0ABC},
        '{8'hE1, 2'h2, 16'h0000, 1'b0, 16'h0002},
        '{8'h55, 2'h0, 16'h0000, 1'b1, 16'h0000},
        '{8'h03, 2'h0, 16'h0000, 1'b0, 16'h0000},
        '{8'hE1, 2'h2, 16'h0000, 1'b0, 16'h0000}
    };

    tss_link_if i_tss_link_if (.clk_i(clk_i));

    tss_host i_tss_host (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .link(i_tss_link_if), .alert_o(alert_h));

    tss_device i_tss_device (.clk_i(clk_i), .rst_i(rst_i), .link(i_tss_link_if),
        .input_current_i(cur), .aux_voltage_i(aux), .input_voltage_i(input_voltage), .power_i(pw),
        .temperature_i(temp), .avg_valid_i(av), .avg_input_current_i(acur),
        .avg_aux_voltage_i(aaux), .avg_input_voltage_i(avin), .avg_power_i(apw),
        .overcurrent_warn_i(cond[5]), .overpower_warn_i(cond[4]), .input_low_warn_i(cond[3]),
        .input_high_warn_i(cond[2]), .overtemp_warn_i(cond[1]), .overtemp_fault_i(cond[0]),
        .range_sel_i(rsel), .alert_o(alert_d), .range_o(range_o), .summary_o(summary),
        .snapshot_armed_o(armed));

    tss_link_sva i_tss_link_sva (.clk_i(clk_i), .rst_i(rst_i), .req(i_tss_link_if.req),
        .xfer(i_tss_link_if.xfer), .cmd(i_tss_link_if.cmd), .wdata(i_tss_link_if.wdata),
        .rvalid(i_tss_link_if.rvalid), .rbyte(i_tss_link_if.rbyte),
        .done(i_tss_link_if.done), .nack(i_tss_link_if.nack));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("compared %0d, wrong %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // Ceiling is about twenty times the expected run length
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Only the bench ceiling ends a stuck wait
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        pr = prdata;
        pe = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask : apb

    task automatic op(input logic [7:0] c, input logic [1:0] x, input logic [15:0] wd);
        apb(1'b1, `TSS_APB_WDATA, {16'h0000, wd});
        apb(1'b1, `TSS_APB_CTRL, {15'h0000, 1'b1, 6'h00, x, c});
        do begin
            apb(1'b0, `TSS_APB_STATUS, 32'h0);
        end while (pr[0] !== 1'b0);
        nk = pr[1];
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(`TSS_APB_RDATA0 + 4 * i), 32'h0);
            rd[32 * i +: 32] = pr;
        end
        apb(1'b0, `TSS_APB_COUNT, 32'h0);
        cnt = pr[7:0];
    endtask : op

    initial begin
        {rst_i, psel, penable, pwrite, av, rsel, cond} = {1'b1, 11'h000};
        {paddr, pwdata, cur, input_voltage, pw, acur, aaux, avin, apw, temp} = '0;
        aux = 12'h500;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            op(rows[i].cmd, rows[i].xf, rows[i].wd);
            chk(96'(nk), 96'(rows[i].nk));
            if (rows[i].xf == 2'h2)
                chk(96'(rd[15:0]), 96'(rows[i].rd));
        end
        $display("table test done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        op(8'hE1, 2'h2, 16'h0);
        chk(96'({rd[15:0], armed}), 96'h00101);
        op(8'hE3, 2'h2, 16'h0);
        chk(96'(rd[15:0]), 96'h0FFF);
        apb(1'b0, 8'h1C, 32'h0);
        chk(96'(pe), 96'h1);
        $display("reset test done");
        {cur, aux, input_voltage, pw, temp} <= {12'h111, 12'h300, 12'h333, 12'h444, 16'hABCD};
        op(8'hE3, 2'h1, 16'h0400);
        aux <= 12'h500;
        repeat (8) @(posedge clk_i);
        chk(96'({alert_d, alert_h, armed}), 96'h6);
        {cur, input_voltage, pw, temp} <= {12'h999, 12'h888, 12'h777, 16'h1234};
        {acur, aaux, avin, apw, av} <= {12'h0A1, 12'h0A2, 12'h0A3, 12'h0A4, 1'b1};
        @(posedge clk_i);
        av <= 1'b0;
        snap = {16'hABCD, 16'h0444, 16'h0333, 16'h0500, 16'h0111, 16'h0100};
        op(8'hE0, 2'h3, 16'h0);
        chk(rd, snap);
        chk(96'(cnt), 96'h0C);
        op(8'hE2, 2'h3, 16'h0);
        chk(rd, {16'h1234, 16'h00A4, 16'h00A3, 16'h00A2, 16'h00A1, 16'h0100});
        $display("snapshot test done");
        // Second alert cause while disarmed must leave the copy alone
        op(8'hE4, 2'h1, 16'h0800);
        op(8'hE0, 2'h3, 16'h0);
        chk(rd, snap);
        op(8'hE1, 2'h2, 16'h0);
        chk(96'(rd[15:0]), 96'h0300);
        op(8'hE3, 2'h1, 16'h0FFF);
        op(8'hE4, 2'h1, 16'h0000);
        op(8'h03, 2'h0, 16'h0);
        aux <= 12'h000;
        repeat (4) @(posedge clk_i);
        aux <= 12'hFFF;
        repeat (4) @(posedge clk_i);
        chk(96'({summary, alert_d, armed}), 96'h00001);
        {cur, cond} <= {12'h765, 6'h3F};
        @(posedge clk_i);
        cond <= 6'h00;
        repeat (6) @(posedge clk_i);
        op(8'hE1, 2'h2, 16'h0);
        chk(96'(rd[15:0]), 96'h7404);
        op(8'hE0, 2'h3, 16'h0);
        chk(rd, {16'h1234, 16'h0777, 16'h0888, 16'h0FFF, 16'h0765, 16'h7404});
        rsel <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(96'(range_o), 96'h1);
        $display("rearm test done");
        complete_run();
    end
endmodule : telemetry_snapshot_status_bench
